/* rtl/sfwp_status.sv */
// Status register and write protection for a 32K x 8 serial memory.
// Assumes SPI modes 0/3 on sck; sck stands still outside frames.
`timescale 1ns/1ps
`default_nettype none
module sfwp_status (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  input wire logic wp_n,
  output logic so_data,
  output logic so_en_n,
  input wire logic [sfwp_pkg::ADDR_W-1:0] arr_addr,
  output logic arr_wr_ok,
  output logic [7:0] protection_status
);
  // Link domain state
  logic [2:0] bit_cnt_reg;
  logic [7:0] rx_shift_reg;
  logic [1:0] byte_cnt_reg;
  logic [7:0] opcode_reg;
  logic op_valid_reg;
  logic rd_active_reg;
  logic [7:0] tx_byte_reg;
  logic so_data_reg;
  logic so_en_n_reg;
  logic [2:0] res_kind_reg;
  logic [7:0] res_data_reg;
  logic [7:0] stat_link;

  // Reference domain state
  logic latch_reg;
  // Nonvolatile cells start at the factory value and are never reset
  logic pin_enable_bit_reg = sfwp_pkg::NV_FACTORY[2];
  logic block_guard_hi_reg = sfwp_pkg::NV_FACTORY[1];
  logic block_guard_lo_reg = sfwp_pkg::NV_FACTORY[0];
  logic cs_n_sync;
  logic cs_n_dly_reg;
  logic wp_n_sync;
  logic [2:0] res_kind_sync;
  logic [7:0] res_data_sync;

  // Decodes
  wire logic [7:0] rx_byte;
  wire logic byte_end;
  wire logic first_bit;
  wire logic [2:0] tx_idx;
  wire logic frame_end;
  wire logic pin_blocks;
  wire logic stat_wr_ok;
  wire logic guarded;
  wire logic [7:0] stat_value;
  wire logic opcode_done;
  wire logic data_done;
  wire logic is_stat_rd;
  wire logic is_stat_wr_data;
  wire logic op_is_set;
  wire logic op_is_clr;
  wire logic op_is_mem_wr;
  wire logic [2:0] op_kind;
  wire logic stat_load;

  // Link domain, rising sck

  // Byte assembly, MSB first
  assign rx_byte = {rx_shift_reg[6:0], si};
  assign byte_end = (bit_cnt_reg == 3'h7);
  assign first_bit = (bit_cnt_reg == 3'h0) && (byte_cnt_reg == 2'h0);

  // Frame position decodes
  assign opcode_done = byte_end && (byte_cnt_reg == 2'h0);
  assign data_done = byte_end && (byte_cnt_reg == 2'h1);
  assign is_stat_rd = opcode_done && (rx_byte == sfwp_pkg::OP_STAT_RD);
  assign is_stat_wr_data = data_done && op_valid_reg &&
                           (opcode_reg == sfwp_pkg::OP_STAT_WR);

  // Opcode classes that act at the end of the frame
  assign op_is_set = (rx_byte == sfwp_pkg::OP_LATCH_SET);
  assign op_is_clr = (rx_byte == sfwp_pkg::OP_LATCH_CLR);
  assign op_is_mem_wr = (rx_byte == sfwp_pkg::OP_MEM_WR);
  assign op_kind = op_is_set ? sfwp_pkg::KIND_SET :
                   op_is_clr ? sfwp_pkg::KIND_CLR :
                   op_is_mem_wr ? sfwp_pkg::KIND_MEM_WR :
                   sfwp_pkg::KIND_NONE;

  // Bit counter, cleared while deselected
  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n) begin
      bit_cnt_reg <= 3'h0;
    end else begin
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
    end
  end

  // Receive shift register, cleared while deselected
  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n) begin
      rx_shift_reg <= 8'h00;
    end else begin
      rx_shift_reg <= rx_byte;
    end
  end

  // Byte counter, saturating past the data byte
  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n) begin
      byte_cnt_reg <= 2'h0;
    end else if (byte_end && byte_cnt_reg != 2'h3) begin
      byte_cnt_reg <= byte_cnt_reg + 2'h1;
    end
  end

  // Opcode capture: only the first byte of a frame is a command
  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n) begin
      opcode_reg <= 8'h00;
    end else if (opcode_done) begin
      opcode_reg <= rx_byte;
    end
  end

  // Opcode complete flag for the rest of the frame
  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n) begin
      op_valid_reg <= 1'b0;
    end else if (opcode_done) begin
      op_valid_reg <= 1'b1;
    end
  end

  // Status read: load the live status byte after the opcode
  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n) begin
      rd_active_reg <= 1'b0;
      tx_byte_reg <= 8'h00;
    end else if (is_stat_rd) begin
      rd_active_reg <= 1'b1;
      tx_byte_reg <= stat_link;
    end
  end

  // Frame result kind, kept past the frame so the reference side can act on it
  always_ff @(posedge sck or posedge rst) begin
    if (rst) begin
      res_kind_reg <= sfwp_pkg::KIND_NONE;
    end else if (!cs_n) begin
      if (first_bit) begin
        res_kind_reg <= sfwp_pkg::KIND_NONE;
      end else if (opcode_done) begin
        res_kind_reg <= op_kind;
      end else if (is_stat_wr_data) begin
        // Status write counts only once its data byte is complete
        res_kind_reg <= sfwp_pkg::KIND_STAT_WR;
      end
    end
  end

  // Frame result data: the status write data byte
  always_ff @(posedge sck or posedge rst) begin
    if (rst) begin
      res_data_reg <= 8'h00;
    end else if (!cs_n && is_stat_wr_data) begin
      res_data_reg <= rx_byte;
    end
  end

  // Link domain, falling sck

  // Serial output, MSB first, changed on falling edges
  assign tx_idx = 3'h7 - bit_cnt_reg;

  // Serial data bit
  always_ff @(negedge sck or posedge cs_n) begin
    if (cs_n) begin
      so_data_reg <= 1'b0;
    end else begin
      so_data_reg <= tx_byte_reg[tx_idx];
    end
  end

  // Output enable, driving only in a status read frame
  always_ff @(negedge sck or posedge cs_n) begin
    if (cs_n) begin
      so_en_n_reg <= 1'b1;
    end else begin
      so_en_n_reg <= ~rd_active_reg;
    end
  end

  assign so_data = so_data_reg;
  assign so_en_n = so_en_n_reg;

  // Status image carried into the link domain; static during a frame
  sfwp_sync #(
    .W(8),
    .INIT(8'h00)
  ) u_stat_sync (
    .clk(sck),
    .rst(rst),
    .d(stat_value),
    .q(stat_link)
  );

  // Reference domain

  // Pins and frame results brought onto ref_clk
  sfwp_sync #(
    .W(1),
    .INIT(1'b1)
  ) u_cs_sync (
    .clk(ref_clk),
    .rst(rst),
    .d(cs_n),
    .q(cs_n_sync)
  );

  sfwp_sync #(
    .W(1),
    .INIT(1'b1)
  ) u_wp_sync (
    .clk(ref_clk),
    .rst(rst),
    .d(wp_n),
    .q(wp_n_sync)
  );

  sfwp_sync #(
    .W(11),
    .INIT(11'h000)
  ) u_res_sync (
    .clk(ref_clk),
    .rst(rst),
    .d({res_kind_reg, res_data_reg}),
    .q({res_kind_sync, res_data_sync})
  );

  // Rising select edge detection
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cs_n_dly_reg <= 1'b1;
    end else begin
      cs_n_dly_reg <= cs_n_sync;
    end
  end

  assign frame_end = cs_n_sync && !cs_n_dly_reg;

  // Pin counts only with pin enable set; latch must be set for any write
  assign pin_blocks = pin_enable_bit_reg && !wp_n_sync;
  assign stat_wr_ok = latch_reg && !pin_blocks;

  // Write latch: set, cleared and consumed at the end of a frame
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      latch_reg <= sfwp_pkg::LATCH_RST;
    end else if (frame_end) begin
      unique case (res_kind_sync)
        sfwp_pkg::KIND_SET: latch_reg <= 1'b1;
        sfwp_pkg::KIND_CLR: latch_reg <= 1'b0;
        sfwp_pkg::KIND_STAT_WR: latch_reg <= 1'b0;
        sfwp_pkg::KIND_MEM_WR: latch_reg <= 1'b0;
        default: latch_reg <= latch_reg;
      endcase
    end
  end

  // Status load strobe: a finished, permitted status write frame
  assign stat_load = frame_end && (res_kind_sync == sfwp_pkg::KIND_STAT_WR) && stat_wr_ok;

  // Accepted status write loads only enable and guard bits; no reset here
  always_ff @(posedge ref_clk) begin
    if (stat_load) begin
      pin_enable_bit_reg <= res_data_sync[sfwp_pkg::BIT_PIN_EN];
      block_guard_hi_reg <= res_data_sync[sfwp_pkg::BIT_GUARD_HI];
      block_guard_lo_reg <= res_data_sync[sfwp_pkg::BIT_GUARD_LO];
    end
  end
  // A blocked status write falls through above and changes only the latch, which it clears
  // The latch bit of the written byte is never used

  // Status byte; fixed bits tied to zero, never busy
  assign stat_value = {
    pin_enable_bit_reg,
    3'b000,
    block_guard_hi_reg,
    block_guard_lo_reg,
    latch_reg,
    1'b0
  };

  // Registered copy of the status byte for the core
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      protection_status <= 8'h00;
    end else begin
      protection_status <= stat_value;
    end
  end

  // Array write permission; pin level plays no part
  sfwp_guard u_guard (
    .block_guard_hi(block_guard_hi_reg),
    .block_guard_lo(block_guard_lo_reg),
    .addr(arr_addr),
    .guarded(guarded)
  );

  assign arr_wr_ok = latch_reg && !guarded;

endmodule
`default_nettype wire

/* rtl/sfwp_pkg.sv */
// Constants for the serial memory status register and write protection logic.
// Assumes an SPI slave front end in modes 0 and 3, opcode first, MSB first.
package sfwp_pkg;
  // Opcodes
  localparam logic [7:0] OP_LATCH_SET = 8'h06;
  localparam logic [7:0] OP_LATCH_CLR = 8'h04;
  localparam logic [7:0] OP_STAT_RD = 8'h05;
  localparam logic [7:0] OP_STAT_WR = 8'h01;
  localparam logic [7:0] OP_MEM_WR = 8'h02;
  // Status bit positions
  localparam int BIT_BUSY = 0;
  localparam int BIT_LATCH = 1;
  localparam int BIT_GUARD_LO = 2;
  localparam int BIT_GUARD_HI = 3;
  localparam int BIT_PIN_EN = 7;
  // Values after reset and factory defaults
  localparam logic LATCH_RST = 1'b0;
  localparam logic [2:0] NV_FACTORY = 3'h0;
  // Array geometry and guarded range bases
  localparam int ADDR_W = 15;
  localparam logic [14:0] GUARD_QTR_BASE = 15'h6000;
  localparam logic [14:0] GUARD_HALF_BASE = 15'h4000;
  // Frame result codes passed from the link domain
  localparam logic [2:0] KIND_NONE = 3'h0;
  localparam logic [2:0] KIND_SET = 3'h1;
  localparam logic [2:0] KIND_CLR = 3'h2;
  localparam logic [2:0] KIND_STAT_WR = 3'h3;
  localparam logic [2:0] KIND_MEM_WR = 3'h4;
  // Synchroniser depth
  localparam int SYNC_STAGES = 2;
endpackage

/* rtl/sfwp_sync.sv */
// Two-stage level synchroniser for a bus of quasi-static bits.
// Assumes the data are stable long enough to pass together.
`timescale 1ns/1ps
`default_nettype none
module sfwp_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_reg;
  // First stage feeds only the second
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_reg <= INIT;
      q <= INIT;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule
`default_nettype wire

/* rtl/sfwp_guard.sv */
// Decode of the two guard bits into a protected address test.
// Assumes a 15-bit array address; purely combinational.
`timescale 1ns/1ps
`default_nettype none
module sfwp_guard (
  input wire logic block_guard_hi,
  input wire logic block_guard_lo,
  input wire logic [sfwp_pkg::ADDR_W-1:0] addr,
  output logic guarded
);
  wire logic in_qtr;
  wire logic in_half;
  // Range compares for upper quarter and upper half
  assign in_qtr = (addr >= sfwp_pkg::GUARD_QTR_BASE);
  assign in_half = (addr >= sfwp_pkg::GUARD_HALF_BASE);
  // Guard select: none, quarter, half, all
  always_comb begin
    unique case ({block_guard_hi, block_guard_lo})
      2'b00: guarded = 1'b0;
      2'b01: guarded = in_qtr;
      2'b10: guarded = in_half;
      2'b11: guarded = 1'b1;
    endcase
  end
endmodule
`default_nettype wire

/* test/sfwp_status_props.sv */
// Checker: status byte, array write gate, serial status output.
// Assumes mode 0 frames at the status block's ports.
`timescale 1ns/1ps
`default_nettype none
module sfwp_status_props (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  input wire logic so_data,
  input wire logic so_en_n,
  input wire logic [sfwp_pkg::ADDR_W-1:0] arr_addr,
  input wire logic arr_wr_ok,
  input wire logic [7:0] protection_status
);
  logic [5:0] cnt;
  logic [7:0] op;
  // Guarded range of a guard pair
  function automatic logic gd(input logic [1:0] g, input logic [14:0] x);
    return g == 2'h3 || (g == 2'h2 && x[14]) || (g == 2'h1 && x[14:13] == 2'h3);
  endfunction
  // Bit count and opcode of the frame
  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n) begin
      cnt <= 6'h00;
      op <= 8'h00;
    end else begin
      cnt <= cnt + 6'h01;
      if (cnt < 6'h08) op <= {op[6:0], si};
    end
  end
  AST_FIXED: assert property (@(posedge ref_clk) disable iff (rst)
    (protection_status & 8'h71) == 8'h00) else $error("fixed bit set");
  AST_ARR: assert property (@(posedge ref_clk) disable iff (rst) 1 |=>
    $past(arr_wr_ok) == (protection_status[1] && !gd(protection_status[3:2], $past(arr_addr))))
    else $error("array gate wrong");
  AST_SET: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(protection_status[1]) |-> cs_n) else $error("latch set in frame");
  AST_HOLD: assert property (@(posedge ref_clk) disable iff (rst)
    !cs_n [*8] |-> $stable(protection_status)) else $error("status moved in frame");
  AST_GATE: assert property (@(posedge ref_clk) disable iff (rst)
    $changed(protection_status[7:2]) |-> $past(protection_status[1]) || $past(rst, 2))
    else $error("status load without latch");
  AST_CLR: assert property (@(posedge ref_clk) disable iff (rst)
    $changed(protection_status[7:2]) |-> !protection_status[1]) else $error("latch kept");
  AST_IDLE: assert property (@(posedge ref_clk) disable iff (rst)
    cs_n [*2] |-> so_en_n) else $error("output on while idle");
  AST_SO: assert property (@(posedge sck) disable iff (cs_n)
    op == 8'h05 && cnt >= 6'h08 |-> !so_en_n && so_data == protection_status[~cnt[2:0]])
    else $error("status bit wrong");
  AST_QUIET: assert property (@(posedge sck) disable iff (cs_n)
    op != 8'h05 |-> so_en_n) else $error("output on in other frame");
  // Main scenarios
  cover property (@(posedge sck) cnt == 6'h0F && op == 8'h05);
  cover property (@(posedge ref_clk) $rose(protection_status[1]));
  cover property (@(posedge ref_clk) $changed(protection_status[7:2]));
endmodule
`default_nettype wire

/* test/sfwp_spi_master.sv */
// SPI master model: mode 0 frames on a 32 ns clock.
// Assumes one caller; keeps select high 320 ns after each frame.
`timescale 1ns/1ps
`default_nettype none
module sfwp_spi_master (
  output logic sck,
  output logic cs_n,
  output logic si,
  input wire logic so_data,
  input wire logic so_en_n,
  output logic [7:0] rd_byte,
  output logic rd_done
);
  // Idle bus: clock still, select high
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
    rd_byte = 8'h00;
    rd_done = 1'b0;
  end
  // Shift n bits of w; a released output reads as unknown
  task automatic xfer(input logic [15:0] w, input int n);
    logic [7:0] rx;
    rx = 8'h00;
    cs_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      si = w[15 - i];
      #16 sck = 1'b1;
      rx = {rx[6:0], so_en_n ? 1'bx : so_data};
      #16 sck = 1'b0;
    end
    #16 cs_n = 1'b1;
    si = ~si;
    if (w[15:8] == 8'h05 && n == 16) begin
      rd_byte = rx;
      rd_done = 1'b1;
      #1 rd_done = 1'b0;
    end
    #320;
  endtask
endmodule
`default_nettype wire

/* test/tb.sv */
// Bench for the status register and write protection block.
// Assumes the master model; the checker is bound at the foot.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic ref_clk, rst, wp_n, arr_wr_ok, so_data, so_en_n, sck, cs_n, si, rd_done;
  logic [14:0] arr_addr, a;
  logic [7:0] protection_status, rd_byte;
  logic [7:0] exp_q[$];
  logic [14:0] bnd[5] = '{15'h3FFF, 15'h4000, 15'h5FFF, 15'h6000, 15'h7FFF};
  int n_fail = 0;
  int cmp_count = 0;
  sfwp_status sfwp_status_i (.ref_clk(ref_clk), .rst(rst), .sck(sck), .cs_n(cs_n), .si(si),
    .wp_n(wp_n), .so_data(so_data), .so_en_n(so_en_n), .arr_addr(arr_addr),
    .arr_wr_ok(arr_wr_ok), .protection_status(protection_status));
  sfwp_spi_master sfwp_spi_master_i (.sck(sck), .cs_n(cs_n), .si(si), .so_data(so_data),
    .so_en_n(so_en_n), .rd_byte(rd_byte), .rd_done(rd_done));
  // Reference clock
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic stop_test;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic cmd(input logic [7:0] op);
    sfwp_spi_master_i.xfer({op, 8'h00}, 8);
  endtask
  task automatic wsr(input logic [7:0] d);
    sfwp_spi_master_i.xfer({8'h01, d}, 16);
  endtask
  task automatic rsr(input logic [7:0] e);
    exp_q.push_back(e);
    sfwp_spi_master_i.xfer({8'h05, 8'h00}, 16);
  endtask
  function automatic logic gd(input int g, input logic [14:0] x);
    return g == 3 || (g == 2 && x[14]) || (g == 1 && x[14:13] == 2'h3);
  endfunction
  // Each byte read back against the oldest note
  always @(posedge rd_done) begin
    if (exp_q.size() > 0) check(rd_byte, exp_q.pop_front());
    else n_fail++;
  end
  // Hang guard
  initial begin
    #200000;
    n_fail++;
    stop_test();
  end
  // Main sequence
  initial begin
    rst = 1'b1;
    wp_n = 1'b1;
    arr_addr = 15'h0000;
    void'($urandom(70));
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rsr(8'h00);
    wsr(8'h8C);
    rsr(8'h00);
    for (int g = 0; g < 4; g++) begin
      cmd(8'h06);
      wsr({4'h7, 2'(g), 2'h3});
      rsr({4'h0, 2'(g), 2'h0});
      cmd(8'h06);
      rsr({4'h0, 2'(g), 2'h2});
      for (int k = 0; k < 6; k++) begin
        a = (k < 5) ? bnd[k] : 15'($urandom);
        @(posedge ref_clk);
        arr_addr <= a;
        wp_n <= ~k[0];
        @(negedge ref_clk);
        check(8'(arr_wr_ok), 8'(!gd(g, a)));
      end
    end
    cmd(8'h04);
    rsr(8'h0C);
    @(negedge ref_clk);
    check(8'(arr_wr_ok), 8'h00);
    cmd(8'h06);
    cmd(8'h02);
    rsr(8'h0C);
    @(posedge ref_clk) wp_n <= 1'b1;
    cmd(8'h06);
    wsr(8'h84);
    rsr(8'h84);
    @(posedge ref_clk) wp_n <= 1'b0;
    cmd(8'h06);
    wsr(8'h00);
    rsr(8'h84);
    @(posedge ref_clk) wp_n <= 1'b1;
    cmd(8'h06);
    wsr(8'h08);
    rsr(8'h08);
    cmd(8'h06);
    @(posedge ref_clk) rst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
    check(protection_status, 8'h08);
    rsr(8'h08);
    check(8'(exp_q.size()), 8'h00);
    stop_test();
  end
endmodule
bind sfwp_status sfwp_status_props sfwp_status_props_i (.ref_clk(ref_clk), .rst(rst),
  .sck(sck), .cs_n(cs_n), .si(si), .so_data(so_data), .so_en_n(so_en_n),
  .arr_addr(arr_addr), .arr_wr_ok(arr_wr_ok), .protection_status(protection_status));
`default_nettype wire
